// ==== dram_chip_model.sv ====
`timescale 1ns/1ps
module dram_chip_model (
  input  wire logic                                core_clk,
  input  wire logic [dram_ctrl_pkg::PIN_ADDR_W-1:0] dram_addr,
  input  wire dram_ctrl_pkg::dram_pins_t           dram_pins,
  input  wire logic [3:0]                          nwait,
  output logic                                     wait_n,
  output logic      [dram_ctrl_pkg::PIN_ADDR_W-1:0] row_q,
  output logic      [dram_ctrl_pkg::PIN_ADDR_W-1:0] col_q
);
  import dram_ctrl_pkg::*;
  logic       cas_low;
  logic       ras_q;
  logic [3:0] cnt_q;
  assign cas_low = !dram_pins.upper_column_strobe_n || !dram_pins.lower_column_strobe_n;
  // Slow chip: pulls wait_n low for the first nwait cycles of every column phase, even in short pitch, where the controller ignores it
  assign wait_n = !(cas_low && cnt_q < nwait);
  always_ff @(posedge core_clk) begin
    ras_q <= dram_pins.ras_n;
    cnt_q <= cas_low ? cnt_q + 4'h1 : 4'h0;
    if (ras_q && !dram_pins.ras_n) row_q <= dram_addr;
    if (cas_low && cnt_q == 4'h0) col_q <= dram_addr;
  end
endmodule : dram_chip_model

// ==== dram_ctrl_monitor.sv ====
`timescale 1ns/1ps
module dram_ctrl_monitor (
  input wire logic                      core_clk,
  input wire logic                      resetn,
  input wire logic                      acc_start,
  input wire logic                      acc_done,
  input wire logic                      refresh_done,
  input wire dram_ctrl_pkg::dram_pins_t dram_pins,
  input wire logic                      cas_short_high,
  input wire logic                      busy
);
  import dram_ctrl_pkg::*;
  logic cas_lo;
  assign cas_lo = !dram_pins.upper_column_strobe_n || !dram_pins.lower_column_strobe_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_done_cause: assert property (
    acc_done |-> $past(acc_start) || $past(busy)) else $error("done without request");
  a_strobe_busy: assert property (
    cas_lo |-> busy) else $error("column strobe while idle");
  a_col_after_row: assert property (
    $fell(dram_pins.ras_n) && !cas_lo |=> cas_lo) else $error("no column after row");
  a_done_single: assert property (
    acc_done |=> !acc_done) else $error("done longer than one cycle");
  a_done_bound: assert property (
    acc_start && !busy |-> ##[1:64] acc_done) else $error("access never finished");
  a_cbr_ras_fall: assert property (
    cas_lo && dram_pins.ras_n |=> !dram_pins.ras_n) else $error("refresh row strobe late");
  a_refresh_ras: assert property (
    $rose(refresh_done) |-> dram_pins.ras_n) else $error("row strobe low after refresh");
  a_upper_we: assert property (
    !dram_pins.upper_write_strobe_n |->
      !dram_pins.lower_column_strobe_n && dram_pins.upper_column_strobe_n)
    else $error("upper write strobe without lower column strobe");
  a_we_with_cas: assert property (
    !dram_pins.lower_write_strobe_n |-> cas_lo && !dram_pins.ras_n)
    else $error("write strobe outside column phase");
  a_short_high: assert property (
    cas_short_high |-> cas_lo) else $error("duty flag outside column phase");

  c_refresh: cover property (refresh_done);
  c_upper_we: cover property (!dram_pins.upper_write_strobe_n);
  c_short_high: cover property (cas_short_high);
endmodule : dram_ctrl_monitor

bind dram_interface_controller dram_ctrl_monitor dram_ctrl_monitor_inst (
  .core_clk(core_clk), .resetn(resetn), .acc_start(acc_start), .acc_done(acc_done),
  .refresh_done(refresh_done), .dram_pins(dram_pins), .cas_short_high(cas_short_high),
  .busy(busy));

// ==== dram_ctrl_pkg.sv ====
package dram_ctrl_pkg;

  localparam int          REG_ADDR_W     = 4;
  localparam int          REG_DATA_W     = 8;
  localparam int          PIN_ADDR_W     = 22;
  localparam int          BUS_ADDR_W     = 24;

  // Register offsets
  localparam logic [3:0]  BCR_OFS        = 4'h0;
  localparam logic [3:0]  DCR_OFS        = 4'h1;
  localparam logic [3:0]  WAIT_CONTROL_REG_ONE_OFS       = 4'h2;
  localparam logic [3:0]  WAIT_CONTROL_REG_TWO_OFS       = 4'h3;
  localparam logic [3:0]  RCR_OFS        = 4'h4;
  localparam logic [3:0]  STAT_OFS       = 4'h5;

  // bus_control_reg fields
  localparam int          DRAM_EN_BIT    = 0;
  // dram_area_control_reg fields
  localparam int          MUX_EN_BIT     = 0;
  localparam int          MUX_LO_BIT     = 1;
  localparam int          MUX_HI_BIT     = 2;
  localparam int          CAS_DUTY_BIT   = 3;
  localparam int          PRECHG_BIT     = 4;
  localparam int          DUAL_STB_BIT   = 5;
  localparam int          BURST_BIT      = 6;
  localparam int          RAS_HOLD_BIT   = 7;
  // wait_control_reg_one / _two fields
  localparam int          RD_PITCH_BIT   = 0;
  localparam int          WR_PITCH_BIT   = 1;
  // refresh_control_reg fields
  localparam int          RFW_LO_BIT     = 0;
  localparam int          RFW_HI_BIT     = 1;
  // status register fields
  localparam int          ST_RAS_BIT     = 0;
  localparam int          ST_BUSY_BIT    = 1;
  localparam int          ST_RFPEND_BIT  = 2;
  localparam int          ST_LASTW_BIT   = 3;

  // Reset values
  localparam logic [7:0]  BCR_RESET      = 8'h00;
  localparam logic [7:0]  DCR_RESET      = 8'h00;
  localparam logic [7:0]  WAIT_CONTROL_REG_ONE_RESET     = 8'h00;
  localparam logic [7:0]  WAIT_CONTROL_REG_TWO_RESET     = 8'h00;
  localparam logic [7:0]  RCR_RESET      = 8'h00;

  localparam logic [2:0]  DRAM_AREA      = 3'h1;
  localparam logic [1:0]  SHIFT_8        = 2'h0;
  localparam logic [1:0]  SHIFT_9        = 2'h1;
  localparam logic [1:0]  PRE_SHORT      = 2'h1;
  localparam logic [1:0]  PRE_LONG       = 2'h2;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] addr;
    logic [2:0]            area;
    logic                  write;
    logic                  dma;
    logic                  single_addr;
    logic                  wide;
    logic                  upper;
    logic                  lower;
  } acc_req_t;

  typedef struct packed {
    logic ras_n;
    logic upper_column_strobe_n;
    logic lower_column_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
  } dram_pins_t;

  localparam dram_pins_t PINS_IDLE = 5'h1F;

endpackage : dram_ctrl_pkg

// ==== dram_interface_controller.sv ====
`timescale 1ns/1ps
module dram_interface_controller (
  input  wire logic                                core_clk,
  input  wire logic                                resetn,
  input  wire logic [dram_ctrl_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [dram_ctrl_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [dram_ctrl_pkg::REG_DATA_W-1:0] reg_rdata,
  input  wire logic                                acc_start,
  input  wire dram_ctrl_pkg::acc_req_t             acc_req,
  output logic                                     acc_done,
  input  wire logic                                refresh_req,
  output logic                                     refresh_done,
  input  wire logic                                wait_n,
  output logic      [dram_ctrl_pkg::PIN_ADDR_W-1:0] dram_addr,
  output dram_ctrl_pkg::dram_pins_t                dram_pins,
  output logic                                     cas_short_high,
  output logic                                     busy
);
  import dram_ctrl_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_ROW, ST_COL1, ST_COLW, ST_COL2, ST_SILENT,
    ST_REF_CAS, ST_REF_RAS, ST_REF_WAIT, ST_REF_END
  } state_t;

  logic [7:0]            bcr_q;
  logic [7:0]            dcr_q;
  logic [7:0]            wait_control_reg_one_q;
  logic [7:0]            wait_control_reg_two_q;
  logic [7:0]            rcr_q;
  state_t                state_q;
  state_t                state_d;
  acc_req_t              cur_q;
  logic [1:0]            cnt_q;
  logic [1:0]            cnt_d;
  logic                  ras_active_q;
  logic                  ras_active_d;
  logic [BUS_ADDR_W-1:0] last_row_q;
  logic                  last_write_q;
  logic                  rf_pend_q;

  logic                  is_dram;
  logic                  hit;
  logic                  req_long;
  logic                  cur_long;
  logic                  take;
  logic                  finish;
  logic [1:0]            shift_sel;
  logic [1:0]            ref_waits;
  acc_req_t              strb_req;
  logic                  col_phase;
  logic                  ref_phase;
  logic [7:0]            status_word;

  // Row part of an address for the programmed shift
  function automatic logic [BUS_ADDR_W-1:0] row_of(input logic [BUS_ADDR_W-1:0] a,
                                                   input logic [1:0] sel);
    if (sel == SHIFT_8) begin
      row_of = a >> 8;
    end else if (sel == SHIFT_9) begin
      row_of = a >> 9;
    end else begin
      row_of = a >> 10;
    end
  endfunction : row_of

  // Pitch bit that covers this kind of access
  function automatic logic pitch_of(input acc_req_t r, input logic [7:0] w1,
                                    input logic [7:0] w2);
    if (r.dma) begin
      pitch_of = r.write ? w2[WR_PITCH_BIT] : w2[RD_PITCH_BIT];
    end else begin
      pitch_of = r.write ? w1[WR_PITCH_BIT] : w1[RD_PITCH_BIT];
    end
  endfunction : pitch_of

  // Column phase of the sequencer, where byte strobes are driven
  function automatic logic is_col(input state_t s);
    is_col = (s == ST_COL1) || (s == ST_COLW) || (s == ST_COL2);
  endfunction : is_col

  // Refresh states that keep both column strobes low
  function automatic logic is_ref(input state_t s);
    is_ref = (s == ST_REF_CAS) || (s == ST_REF_RAS) || (s == ST_REF_WAIT);
  endfunction : is_ref

  // Status snapshot for software
  assign status_word = {4'h0, last_write_q, rf_pend_q, busy, ras_active_q};

  // Which access the strobes describe, and in which phase
  always_comb begin
    strb_req  = (state_q == ST_IDLE) ? acc_req : cur_q;
    col_phase = is_col(state_d);
    ref_phase = is_ref(state_d);
  end

  assign shift_sel = {dcr_q[MUX_HI_BIT], dcr_q[MUX_LO_BIT]};
  assign ref_waits = {rcr_q[RFW_HI_BIT], rcr_q[RFW_LO_BIT]};
  assign is_dram   = bcr_q[DRAM_EN_BIT] && (acc_req.area == DRAM_AREA);
  assign req_long  = pitch_of(acc_req, wait_control_reg_one_q, wait_control_reg_two_q);
  assign cur_long  = pitch_of(cur_q, wait_control_reg_one_q, wait_control_reg_two_q);
  // Page hit, independent of which master issued either access
  assign hit       = dcr_q[BURST_BIT] && ras_active_q
                     && (row_of(acc_req.addr, shift_sel) == last_row_q);
  assign take      = (state_q == ST_IDLE) && !rf_pend_q && acc_start;

  // Register writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bcr_q  <= BCR_RESET;
      dcr_q  <= DCR_RESET;
      wait_control_reg_one_q <= WAIT_CONTROL_REG_ONE_RESET;
      wait_control_reg_two_q <= WAIT_CONTROL_REG_TWO_RESET;
      rcr_q  <= RCR_RESET;
    end else if (reg_wr) begin
      if (reg_addr == BCR_OFS) begin
        bcr_q <= reg_wdata;
      end else if (reg_addr == DCR_OFS) begin
        dcr_q <= reg_wdata;
      end else if (reg_addr == WAIT_CONTROL_REG_ONE_OFS) begin
        wait_control_reg_one_q <= reg_wdata;
      end else if (reg_addr == WAIT_CONTROL_REG_TWO_OFS) begin
        wait_control_reg_two_q <= reg_wdata;
      end else if (reg_addr == RCR_OFS) begin
        rcr_q <= reg_wdata;
      end
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == BCR_OFS) begin
        reg_rdata <= bcr_q;
      end else if (reg_addr == DCR_OFS) begin
        reg_rdata <= dcr_q;
      end else if (reg_addr == WAIT_CONTROL_REG_ONE_OFS) begin
        reg_rdata <= wait_control_reg_one_q;
      end else if (reg_addr == WAIT_CONTROL_REG_TWO_OFS) begin
        reg_rdata <= wait_control_reg_two_q;
      end else if (reg_addr == RCR_OFS) begin
        reg_rdata <= rcr_q;
      end else if (reg_addr == STAT_OFS) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Pending refresh; a new request wins over the clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rf_pend_q <= 1'b0;
    end else if (refresh_req) begin
      rf_pend_q <= 1'b1;
    end else if (state_q == ST_IDLE) begin
      rf_pend_q <= 1'b0;
    end
  end

  // Sequencer
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    ras_active_d = ras_active_q;
    finish       = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (rf_pend_q) begin
          state_d      = ST_REF_CAS;
          ras_active_d = 1'b0;
        end else if (acc_start && !is_dram) begin
          finish = 1'b1;
          if (!dcr_q[RAS_HOLD_BIT]) begin
            ras_active_d = 1'b0;
          end
        end else if (acc_start && hit) begin
          // Short page writes from either master get a gap; single_addr is not looked at
          if (!req_long && acc_req.write) begin
            state_d = ST_SILENT;
          end else begin
            state_d = ST_COL1;
          end
        end else if (acc_start) begin
          state_d      = ST_PRE;
          ras_active_d = 1'b0;
          cnt_d        = dcr_q[PRECHG_BIT] ? PRE_LONG : PRE_SHORT;
        end
      end
      ST_PRE: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == PRE_SHORT) begin
          state_d      = ST_ROW;
          ras_active_d = 1'b1;
        end
      end
      ST_ROW: begin
        state_d = ST_COL1;
      end
      ST_SILENT: begin
        state_d = ST_COL1;
      end
      ST_COL1: begin
        if (cur_long) begin
          state_d = wait_n ? ST_COL2 : ST_COLW;
        end else begin
          state_d = ST_IDLE;
          finish  = 1'b1;
        end
      end
      ST_COLW: begin
        if (wait_n) begin
          state_d = ST_COL2;
        end
      end
      ST_COL2: begin
        state_d = ST_IDLE;
        finish  = 1'b1;
      end
      ST_REF_CAS: begin
        state_d = ST_REF_RAS;
        cnt_d   = ref_waits;
      end
      ST_REF_RAS: begin
        if (wait_control_reg_one_q[RD_PITCH_BIT] && (ref_waits != 2'h0)) begin
          state_d = ST_REF_WAIT;
        end else begin
          state_d = ST_REF_END;
        end
      end
      ST_REF_WAIT: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = ST_REF_END;
        end
      end
      ST_REF_END: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Without bursting every access closes its row
    if (finish && (state_q != ST_IDLE) && !dcr_q[BURST_BIT]) begin
      ras_active_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 2'h0;
      ras_active_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      ras_active_q <= ras_active_d;
    end
  end

  // Latched access and open row
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_q        <= '0;
      last_row_q   <= '0;
      last_write_q <= 1'b0;
    end else if (take && is_dram) begin
      cur_q        <= acc_req;
      last_row_q   <= row_of(acc_req.addr, shift_sel);
      last_write_q <= acc_req.write;
    end
  end

  // Address pins: row phase shifted, column phase unshifted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dram_addr <= '0;
    end else if ((state_d == ST_ROW) && dcr_q[MUX_EN_BIT]) begin
      dram_addr <= last_row_q[PIN_ADDR_W-1:0];
    end else if (state_d == ST_ROW) begin
      dram_addr <= cur_q.addr[PIN_ADDR_W-1:0];
    end else if ((state_d == ST_COL1) && (state_q == ST_IDLE)) begin
      dram_addr <= acc_req.addr[PIN_ADDR_W-1:0];
    end else if (state_d == ST_COL1) begin
      dram_addr <= cur_q.addr[PIN_ADDR_W-1:0];
    end
  end

  // Strobe pins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dram_pins <= PINS_IDLE;
    end else begin
      dram_pins.ras_n <= !(ras_active_d || (state_d == ST_REF_RAS)
                           || (state_d == ST_REF_WAIT));
      if (ref_phase) begin
        dram_pins.upper_column_strobe_n <= 1'b0;
        dram_pins.lower_column_strobe_n <= 1'b0;
        dram_pins.upper_write_strobe_n  <= 1'b1;
        dram_pins.lower_write_strobe_n  <= 1'b1;
      end else if (col_phase && strb_req.wide && !dcr_q[DUAL_STB_BIT]) begin
        dram_pins.upper_column_strobe_n <= !strb_req.upper;
        dram_pins.lower_column_strobe_n <= !strb_req.lower;
        dram_pins.upper_write_strobe_n  <= 1'b1;
        dram_pins.lower_write_strobe_n  <= !strb_req.write;
      end else if (col_phase && strb_req.wide) begin
        dram_pins.upper_column_strobe_n <= 1'b1;
        dram_pins.lower_column_strobe_n <= 1'b0;
        dram_pins.upper_write_strobe_n  <= !(strb_req.write && strb_req.upper);
        dram_pins.lower_write_strobe_n  <= !(strb_req.write && strb_req.lower);
      end else if (col_phase) begin
        dram_pins.upper_column_strobe_n <= 1'b1;
        dram_pins.lower_column_strobe_n <= 1'b0;
        dram_pins.upper_write_strobe_n  <= 1'b1;
        dram_pins.lower_write_strobe_n  <= !strb_req.write;
      end else begin
        dram_pins.upper_column_strobe_n <= 1'b1;
        dram_pins.lower_column_strobe_n <= 1'b1;
        dram_pins.upper_write_strobe_n  <= 1'b1;
        dram_pins.lower_write_strobe_n  <= 1'b1;
      end
    end
  end

  // Handshake and duty select
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_done       <= 1'b0;
      refresh_done   <= 1'b0;
      busy           <= 1'b0;
      cas_short_high <= 1'b0;
    end else begin
      acc_done       <= finish;
      refresh_done   <= (state_q == ST_REF_END);
      busy           <= (state_d != ST_IDLE) || rf_pend_q || refresh_req;
      // Pad timing shortens the CAS high part only in short pitch columns
      cas_short_high <= dcr_q[CAS_DUTY_BIT] && (state_d == ST_COL1)
                        && !((state_q == ST_IDLE) ? req_long : cur_long);
    end
  end

endmodule : dram_interface_controller

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import dram_ctrl_pkg::*;
  localparam logic [5:0]  RD = 6'h07, WR = 6'h27, DRD = 6'h17, DSW = 6'h3F;
  localparam logic [23:0] A  = 24'hC3A5B6;
  logic       core_clk = 1'b0, resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0, nwait = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, acc_start = 1'b0, refresh_req = 1'b0;
  acc_req_t   acc_req = '0;
  logic       acc_done, refresh_done, wait_n, cas_short_high, busy, sh_seen;
  logic [21:0] dram_addr, row_q, col_q, m;
  dram_pins_t dram_pins;
  logic [4:0] seen;
  int         fails = 0, cmp_count = 0, n, n0;
  always #4 core_clk = ~core_clk;

  dram_interface_controller dram_interface_controller_inst (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_start(acc_start),
    .acc_req(acc_req), .acc_done(acc_done), .refresh_req(refresh_req),
    .refresh_done(refresh_done), .wait_n(wait_n), .dram_addr(dram_addr),
    .dram_pins(dram_pins), .cas_short_high(cas_short_high), .busy(busy));
  dram_chip_model dram_chip_model_inst (.core_clk(core_clk), .dram_addr(dram_addr),
    .dram_pins(dram_pins), .nwait(nwait), .wait_n(wait_n), .row_q(row_q), .col_q(col_q));

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr

  // Counts cycles from the accepting edge to the done pulse, noting every strobe seen
  task automatic ac(input logic [23:0] a, input logic [2:0] ar, input logic [5:0] f,
                    input int e);
    @(posedge core_clk);
    acc_start <= 1'b1;
    acc_req <= {a, ar, f};
    @(posedge core_clk);
    acc_start <= 1'b0;
    n = 0;
    seen = 5'h00;
    sh_seen = 1'b0;
    do begin
      #1 n++;
      seen |= ~dram_pins;
      sh_seen |= cas_short_high;
      if (acc_done !== 1'b1) @(posedge core_clk);
    end while (acc_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk("acc_done", 1, 0);
      wrap_up();
    end
    chk("cycles", e, n);
  endtask : ac

  task automatic rfs;
    @(posedge core_clk);
    refresh_req <= 1'b1;
    @(posedge core_clk);
    refresh_req <= 1'b0;
    n = 0;
    do begin
      #1 n++;
      if (refresh_done !== 1'b1) @(posedge core_clk);
    end while (refresh_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      chk("refresh_done", 1, 0);
      wrap_up();
    end
  endtask : rfs

  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdr(i[3:0]);
      chk("reg reset", 0, rd);
    end
    wr(4'hF, 8'hFF);
    rdr(4'hF);
    chk("unmapped", 0, rd);
    wr(DCR_OFS, 8'hA5);
    rdr(DCR_OFS);
    chk("dcr", 8'hA5, rd);
    $display("test registers done");
    wr(DCR_OFS, 8'h01);
    ac(A, DRAM_AREA, RD, 1);
    chk("ras used", 0, seen[4]);
    wr(BCR_OFS, 8'h01);
    ac(A, DRAM_AREA, RD, 4);
    chk("cas used", 1, seen[2]);
    for (int s = 0; s < 3; s++) begin
      wr(DCR_OFS, 8'(2 * s + 1));
      ac(A, DRAM_AREA, RD, 4);
      m = (22'h1 << (16 - s)) - 22'h1;
      chk("row", 22'(A >> (8 + s)) & m, row_q & m);
      chk("col", A[21:0], col_q);
    end
    wr(DCR_OFS, 8'h11);
    ac(A, DRAM_AREA, RD, 5);
    wr(DCR_OFS, 8'h01);
    $display("test full access done");
    for (int k = 0; k < 4; k++) begin
      wr(WAIT_CONTROL_REG_ONE_OFS, k < 2 ? 8'(1 << k) : 8'h00);
      wr(WAIT_CONTROL_REG_TWO_OFS, k > 1 ? 8'(1 << (k - 2)) : 8'h00);
      for (int j = 0; j < 4; j++)
        ac(A, DRAM_AREA, {j[0], j[1], 4'h7}, j == k ? 5 : 4);
    end
    nwait = 4'h3;
    wr(WAIT_CONTROL_REG_TWO_OFS, 8'h00);
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h01);
    ac(A, DRAM_AREA, RD, 8);
    $display("test pitch done");
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h00);
    wr(DCR_OFS, 8'h41);
    ac(A, DRAM_AREA, RD, 4);
    ac(A + 24'h2, DRAM_AREA, RD, 2);
    ac(A, DRAM_AREA, WR, 3);
    ac(A, DRAM_AREA, DRD, 2);
    ac(A, DRAM_AREA, DSW, 3);
    ac(A + 24'h10000, DRAM_AREA, RD, 4);
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h01);
    ac(A + 24'h10000, DRAM_AREA, RD, 6);
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h00);
    $display("test burst done");
    wr(DCR_OFS, 8'hC1);
    ac(A, DRAM_AREA, RD, 4);
    ac(A, 3'h2, RD, 1);
    chk("ras held", 0, dram_pins.ras_n);
    ac(A, DRAM_AREA, RD, 2);
    rfs();
    chk("ras refresh", 1, dram_pins.ras_n);
    ac(A, DRAM_AREA, RD, 4);
    wr(DCR_OFS, 8'h41);
    ac(A, DRAM_AREA, RD, 2);
    ac(A, 3'h2, RD, 1);
    chk("ras up", 1, dram_pins.ras_n);
    ac(A, DRAM_AREA, RD, 4);
    $display("test ras modes done");
    wr(RCR_OFS, 8'h02);
    rfs();
    n0 = n;
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h01);
    rfs();
    chk("refresh waits", 2, n - n0);
    wr(WAIT_CONTROL_REG_ONE_OFS, 8'h00);
    $display("test refresh done");
    wr(DCR_OFS, 8'h01);
    ac(A, DRAM_AREA, 6'h26, 4);
    chk("strobes", 4'h9, seen[3:0]);
    chk("duty flag", 0, sh_seen);
    wr(DCR_OFS, 8'h21);
    ac(A, DRAM_AREA, 6'h26, 4);
    chk("strobes", 4'h6, seen[3:0]);
    ac(A, DRAM_AREA, 6'h21, 4);
    chk("strobes", 4'h5, seen[3:0]);
    wr(DCR_OFS, 8'h09);
    ac(A, DRAM_AREA, RD, 4);
    chk("duty flag", 1, sh_seen);
    $display("test strobes done");
    wrap_up();
  end
endmodule : tb_top
